// File: rtl/monitor_pkg.sv
// Purpose: Shared constants of the stepper hold-brake and fault monitor
// Assumes: ref_clk at 100 MHz
// Notes:   Times in their own unit; cycle counts derive from them
package monitor_pkg;
    // Clock and oscillator rates
    localparam int CLK_KHZ      = 100000;
    localparam int OSC_KHZ_MIN  = 820;
    localparam int OSC_KHZ_NOM  = 3200;
    localparam int OSC_KHZ_MAX  = 8200;
    localparam int AUX_KHZ      = 6400;
    // Chopping off-time window in ns
    localparam int OFF_NS_MIN   = 5000;
    localparam int OFF_NS_NOM   = 10000;
    localparam int OFF_NS_MAX   = 40000;
    // Detection blanking, in aux oscillator ticks
    localparam int HEAT_TICKS   = 32;
    localparam int OVER_TICKS   = 8;
    localparam int WARN_TICKS   = 16;
    // Electrical angle: 16 positions of 22.5 degrees, home at 45 degrees
    localparam logic [3:0] INIT_ANGLE = 4'h2;
    localparam logic [6:0] FULL_PCT   = 7'h64;
    localparam logic [6:0] HIGH_PCT   = 7'h5c;
    localparam logic [6:0] MID_PCT    = 7'h47;
    localparam logic [6:0] LOW_PCT    = 7'h26;
    // Step resolution select codes {step_sel_1, step_sel_2}
    localparam logic [1:0] SEL_STANDBY = 2'h0;
    localparam logic [1:0] SEL_FULL    = 2'h1;
    localparam logic [1:0] SEL_HALF    = 2'h2;
    // Register map
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] MASK_OFS   = 8'h04;
    localparam logic [7:0] STATE_OFS  = 8'h08;
    localparam logic [2:0] MASK_RST   = 3'h0;
    // Status and mask bit positions
    localparam int EV_FAULT = 0;
    localparam int EV_WARN  = 1;
    localparam int EV_HOME  = 2;
endpackage

// File: rtl/sync_agree.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs asynchronous to clk
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module sync_agree #(
    parameter int             W   = 1,
    parameter logic [W-1:0]   RST = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // First stage feeds only the second, so no logic sees a metastable value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
            q_o  <= RST;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                q_o <= s3_q;
            end
        end
    end
endmodule

// File: rtl/stepper_brake_and_fault_monitor.sv
// Purpose: Hold braking, chopping gate and open-drain status flags of a stepper driver
// Assumes: resetn is the motor supply power-on reset; analogue comparators arrive as levels
// Notes:   Open-drain flags pull low while their enable is high; data pins tied low
`timescale 1ns/1ps
// Functional notes
// [R1] Hold with chopping disabled closes all four motor switches together.
// [R2] Angle flag pulls low at the initial angle, released elsewhere.
// [R3] Fault flag released normally, pulls low after heat or overcurrent shutdown.
// [R4] Fault flag stays low until supply reset or a standby cycle.
// [R5] Thermal warning pulls low when hot, releases itself after cooling margin.
// [R6] Chopping is disabled while the threshold input is tied to logic supply.
// [R7] Chopping off-time spans 5 to 40 us, nominal 10 us.
// [R8] Internal oscillator runs between 820 and 8200 kHz, nominal 3200.
// [R9] Heat shutdown accepted only after 32 aux oscillator ticks.
// [R10] Overcurrent accepted only after 8 aux oscillator ticks.
// [R11] Both step selects low enter standby; outputs off, fault latch cleared.
// [R12] Hold forces full-scale ratio while step clocks still advance the angle.
// [R13] Hold, step select and step clock inputs are synchronised first.
module stepper_brake_and_fault_monitor #(
    parameter int OSC_KHZ = monitor_pkg::OSC_KHZ_NOM,
    parameter int OFF_NS  = monitor_pkg::OFF_NS_NOM
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Control pins
    input  wire logic        hold_in,
    input  wire logic        step_sel_1,
    input  wire logic        step_sel_2,
    input  wire logic        step_clk,
    input  wire logic        chop_off_in,
    // Analogue comparator levels
    input  wire logic        thermal_shutdown,
    input  wire logic        overcurrent_shutdown,
    input  wire logic        temp_hot_in,
    input  wire logic        temp_cool_in,
    input  wire logic [1:0]  cur_peak_in,
    // Motor switches {b_neg, b_pos, a_neg, a_pos} and current ratios
    output logic      [3:0]  sw_q,
    output logic      [6:0]  ratio_a_q,
    output logic      [6:0]  ratio_b_q,
    // Open-drain flags
    output logic             angle_home_flag_o,
    output logic             angle_home_flag_oe,
    output logic             fault_flag_o,
    output logic             fault_flag_oe,
    output logic             thermal_warn_flag_o,
    output logic             thermal_warn_flag_oe,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq
);
    // Clamp settings into the supported window
    localparam int OSC_C  = (OSC_KHZ < monitor_pkg::OSC_KHZ_MIN) ? monitor_pkg::OSC_KHZ_MIN :
                            (OSC_KHZ > monitor_pkg::OSC_KHZ_MAX) ? monitor_pkg::OSC_KHZ_MAX : OSC_KHZ;
    localparam int OFF_C  = (OFF_NS < monitor_pkg::OFF_NS_MIN) ? monitor_pkg::OFF_NS_MIN :
                            (OFF_NS > monitor_pkg::OFF_NS_MAX) ? monitor_pkg::OFF_NS_MAX : OFF_NS;
    localparam int OSC_DIV = monitor_pkg::CLK_KHZ / OSC_C;
    localparam int AUX_DIV = monitor_pkg::CLK_KHZ / monitor_pkg::AUX_KHZ;
    localparam int OFF_TK  = (OFF_C * OSC_C + 999999) / 1000000;
    localparam logic [8:0] OFF_TICKS = 9'(OFF_TK);

    logic       hold_s;
    logic [1:0] sel_s;
    logic       step_s;
    logic       chop_off_s;
    logic [3:0] cond_s;
    logic [1:0] peak_s;
    logic       step_d_q;
    logic [6:0] osc_cnt_q;
    logic [6:0] aux_cnt_q;
    logic       osc_tick;
    logic       aux_tick;
    logic [3:0] hit;
    logic [5:0] flt_cnt_q [4];
    logic       standby_function;
    logic [3:0] angle_q;
    logic       fault_q;
    logic       warn_q;
    logic [8:0] off_q [2];
    logic [1:0] load;
    logic [6:0] mag_a;
    logic [6:0] mag_b;
    logic       neg_a;
    logic       neg_b;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [2:0] event_w;
    logic       home_q;

    // Pin inputs cross into the clock domain
    sync_agree #(.W(5)) u_ctl_sync ( // [R13]
        .clk    (ref_clk),
        .resetn (resetn),
        .d_i    ({hold_in, step_sel_1, step_sel_2, step_clk, chop_off_in}),
        .q_o    ({hold_s, sel_s, step_s, chop_off_s})
    );
    sync_agree #(.W(6)) u_ana_sync (
        .clk    (ref_clk),
        .resetn (resetn),
        .d_i    ({temp_cool_in, temp_hot_in, overcurrent_shutdown, thermal_shutdown, cur_peak_in}),
        .q_o    ({cond_s, peak_s})
    );

    assign standby_function = (sel_s == monitor_pkg::SEL_STANDBY); // [R11]

    // Main oscillator tick; the standby gate stops it to save power
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            osc_cnt_q <= 7'h00;
        end else if (standby_function || osc_cnt_q == 7'(OSC_DIV - 1)) begin // [R8]
            osc_cnt_q <= 7'h00;
        end else begin
            osc_cnt_q <= osc_cnt_q + 7'h01;
        end
    end
    assign osc_tick = !standby_function && (osc_cnt_q == 7'(OSC_DIV - 1));

    // Aux oscillator tick used for detection blanking
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            aux_cnt_q <= 7'h00;
        end else if (aux_cnt_q == 7'(AUX_DIV - 1)) begin
            aux_cnt_q <= 7'h00;
        end else begin
            aux_cnt_q <= aux_cnt_q + 7'h01;
        end
    end
    assign aux_tick = (aux_cnt_q == 7'(AUX_DIV - 1));

    // Blanking filters: heat, overcurrent, hot, cool; short glitches restart the count
    for (genvar i = 0; i < 4; i++) begin : g_flt
        localparam int LIM = (i == 0) ? monitor_pkg::HEAT_TICKS :
                             (i == 1) ? monitor_pkg::OVER_TICKS : monitor_pkg::WARN_TICKS;
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                flt_cnt_q[i] <= 6'h00;
            end else if (!cond_s[i]) begin
                flt_cnt_q[i] <= 6'h00;
            end else if (aux_tick && flt_cnt_q[i] != 6'(LIM)) begin // [R9] [R10]
                flt_cnt_q[i] <= flt_cnt_q[i] + 6'h01;
            end
        end
        assign hit[i] = (flt_cnt_q[i] == 6'(LIM));
    end

    // Fault latch; a detection in the same cycle as standby still wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fault_q <= 1'b0;
        end else if (hit[0] || hit[1]) begin // [R3] [R9] [R10]
            fault_q <= 1'b1;
        end else if (standby_function) begin // [R4] [R11]
            fault_q <= 1'b0;
        end
    end

    // Thermal warning with hysteresis between the two comparators
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            warn_q <= 1'b0;
        end else if (hit[2]) begin // [R5]
            warn_q <= 1'b1;
        end else if (hit[3]) begin // [R5]
            warn_q <= 1'b0;
        end
    end

    // Electrical angle advances on each step clock outside standby, also during hold
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            step_d_q <= 1'b0;
            angle_q  <= monitor_pkg::INIT_ANGLE;
        end else begin
            step_d_q <= step_s;
            if (standby_function) begin // [R11]
                angle_q <= monitor_pkg::INIT_ANGLE;
            end else if (step_s && !step_d_q) begin // [R12]
                case (sel_s)
                    monitor_pkg::SEL_FULL: angle_q <= angle_q + 4'h4;
                    monitor_pkg::SEL_HALF: angle_q <= angle_q + 4'h2;
                    default:               angle_q <= angle_q + 4'h1;
                endcase
            end
        end
    end

    // Magnitude of one phase at offset k into a quadrant
    function automatic logic [6:0] mag_of(input logic [2:0] k, input logic quarter);
        logic [6:0] m;
        m = 7'h00;
        case (k)
            3'h0:    m = monitor_pkg::FULL_PCT;
            3'h1:    m = monitor_pkg::HIGH_PCT;
            3'h2:    m = quarter ? monitor_pkg::MID_PCT : monitor_pkg::FULL_PCT;
            3'h3:    m = monitor_pkg::LOW_PCT;
            default: m = 7'h00;
        endcase
        return m;
    endfunction

    // Phase A follows cosine, phase B sine of the angle
    always_comb begin
        logic q;
        q     = (sel_s == 2'h3);
        mag_a = angle_q[2] ? mag_of(3'h4 - {1'b0, angle_q[1:0]}, q) : mag_of({1'b0, angle_q[1:0]}, q);
        mag_b = angle_q[2] ? mag_of({1'b0, angle_q[1:0]}, q) : mag_of(3'h4 - {1'b0, angle_q[1:0]}, q);
        neg_a = (angle_q[3:2] == 2'h1) || (angle_q[3:2] == 2'h2);
        neg_b = angle_q[3];
    end

    // Ratio outputs; hold forces full scale
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ratio_a_q <= monitor_pkg::FULL_PCT;
            ratio_b_q <= monitor_pkg::FULL_PCT;
        end else if (hold_s) begin // [R12]
            ratio_a_q <= monitor_pkg::FULL_PCT;
            ratio_b_q <= monitor_pkg::FULL_PCT;
        end else begin
            ratio_a_q <= mag_a;
            ratio_b_q <= mag_b;
        end
    end

    // Fixed off-time per phase after the peak comparator trips
    assign load[0] = !chop_off_s && !standby_function && peak_s[0] && off_q[0] == 9'h000 && sw_q[1:0] != 2'h0; // [R6]
    assign load[1] = !chop_off_s && !standby_function && peak_s[1] && off_q[1] == 9'h000 && sw_q[3:2] != 2'h0; // [R6]
    for (genvar p = 0; p < 2; p++) begin : g_off
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                off_q[p] <= 9'h000;
            end else if (chop_off_s || standby_function) begin
                off_q[p] <= 9'h000;
            end else if (load[p]) begin
                off_q[p] <= OFF_TICKS; // [R7]
            end else if (osc_tick && off_q[p] != 9'h000) begin
                off_q[p] <= off_q[p] - 9'h001;
            end
        end
    end

    // Output switches; shutdown and standby win over everything
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sw_q <= 4'h0;
        end else if (standby_function || fault_q) begin // [R11]
            sw_q <= 4'h0;
        end else if (hold_s && chop_off_s) begin // [R1]
            sw_q <= 4'hf;
        end else begin
            sw_q[0] <= (hold_s || mag_a != 7'h00) && off_q[0] == 9'h000 && !load[0] && !neg_a;
            sw_q[1] <= (hold_s || mag_a != 7'h00) && off_q[0] == 9'h000 && !load[0] && neg_a;
            sw_q[2] <= (hold_s || mag_b != 7'h00) && off_q[1] == 9'h000 && !load[1] && !neg_b;
            sw_q[3] <= (hold_s || mag_b != 7'h00) && off_q[1] == 9'h000 && !load[1] && neg_b;
        end
    end

    // Open-drain enables, registered
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            home_q               <= 1'b0;
            angle_home_flag_oe   <= 1'b0;
            fault_flag_oe        <= 1'b0;
            thermal_warn_flag_oe <= 1'b0;
        end else begin
            home_q               <= (angle_q == monitor_pkg::INIT_ANGLE);
            angle_home_flag_oe   <= (angle_q == monitor_pkg::INIT_ANGLE); // [R2]
            fault_flag_oe        <= fault_q; // [R3] [R4]
            thermal_warn_flag_oe <= warn_q; // [R5]
        end
    end
    assign angle_home_flag_o   = 1'b0;
    assign fault_flag_o        = 1'b0;
    assign thermal_warn_flag_o = 1'b0;

    // Sticky events: fault latched, warning raised, home angle reached
    assign event_w = {(angle_q == monitor_pkg::INIT_ANGLE) && !home_q,
                      hit[2] && !warn_q, (hit[0] || hit[1]) && !fault_q};

    // Status is write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= 3'h0;
            mask_q   <= monitor_pkg::MASK_RST;
        end else begin
            if (reg_wr && reg_addr == monitor_pkg::STATUS_OFS) begin
                status_q <= (status_q & ~reg_wdata[2:0]) | event_w;
            end else begin
                status_q <= status_q | event_w;
            end
            if (reg_wr && reg_addr == monitor_pkg::MASK_OFS) begin
                mask_q <= reg_wdata[2:0];
            end
        end
    end
    assign irq = |(status_q & mask_q);

    // Read data stand one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                monitor_pkg::STATUS_OFS: reg_rdata <= {29'h0, status_q};
                monitor_pkg::MASK_OFS:   reg_rdata <= {29'h0, mask_q};
                monitor_pkg::STATE_OFS:  reg_rdata <= {11'h000, ratio_b_q, ratio_a_q, standby_function,
                                                       warn_q, fault_q, angle_q};
                default:                 reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    brake_all_on_a: assert property (hold_s && chop_off_s && !standby_function && !fault_q |=> sw_q == 4'hf) // [R1]
        else $error("hold without chopping did not close all switches");
    home_flag_a: assert property (resetn && $past(resetn) |-> // [R2]
        angle_home_flag_oe == ($past(angle_q) == monitor_pkg::INIT_ANGLE))
        else $error("home flag does not follow angle");
    fault_set_a: assert property (hit[0] || hit[1] |=> fault_q ##1 fault_flag_oe) // [R3]
        else $error("fault flag did not pull low after shutdown");
    fault_keep_a: assert property (fault_q && !standby_function |=> fault_q) // [R4]
        else $error("fault latch released without standby");
    warn_hyst_a: assert property (hit[3] && !hit[2] |=> !warn_q ##1 !thermal_warn_flag_oe) // [R5]
        else $error("warning not released after cooling");
    chop_gate_a: assert property (chop_off_s |-> load == 2'h0 ##1 off_q[0] == 9'h000) // [R6]
        else $error("chopping active while disabled");
    off_load_a: assert property (load[0] && !chop_off_s |=> off_q[0] == OFF_TICKS) // [R7]
        else $error("off-time loaded with wrong count");
    osc_gap_a: assert property (osc_tick |=> !osc_tick [*8]) // [R8]
        else $error("main oscillator tick too frequent");
    heat_blank_a: assert property ($rose(hit[0]) |-> $past(flt_cnt_q[0]) == 6'(monitor_pkg::HEAT_TICKS - 1)) // [R9]
        else $error("heat shutdown accepted early");
    over_blank_a: assert property ($rose(hit[1]) |-> $past(flt_cnt_q[1]) == 6'(monitor_pkg::OVER_TICKS - 1)) // [R10]
        else $error("overcurrent accepted early");
    standby_off_a: assert property (standby_function |=> sw_q == 4'h0 && angle_q == monitor_pkg::INIT_ANGLE) // [R11]
        else $error("standby did not stop outputs");
    hold_ratio_a: assert property (hold_s |=> ratio_a_q == monitor_pkg::FULL_PCT) // [R12]
        else $error("hold did not force full ratio");

    brake_seen_c: cover property (hold_s && chop_off_s ##1 sw_q == 4'hf);
    fault_seen_c: cover property ($rose(fault_q));
    warn_cycle_c: cover property ($rose(warn_q) ##[1:1000] $fell(warn_q));
    home_again_c: cover property ($fell(home_q) ##[1:1000] $rose(home_q));
endmodule

// File: dv/host_flag_model.sv
// Purpose: Host controller side of the three open-drain status flags
// Assumes: Each flag line has a pull-up resistor to the logic supply
// Notes:   A released line reads high, never the last driven value
`timescale 1ns/1ps
module host_flag_model (
    // Flag drivers from the device
    input  wire logic home_o,
    input  wire logic home_oe,
    input  wire logic fault_o,
    input  wire logic fault_oe,
    input  wire logic warn_o,
    input  wire logic warn_oe,
    // Resolved line levels seen by the host
    output logic      home_pin,
    output logic      fault_pin,
    output logic      warn_pin
);
    // Pull-up wins whenever the device lets go of a line
    assign home_pin  = home_oe  ? home_o  : 1'b1;
    assign fault_pin = fault_oe ? fault_o : 1'b1;
    assign warn_pin  = warn_oe  ? warn_o  : 1'b1;
endmodule

// File: dv/tb_stepper_brake_and_fault_monitor.sv
// Purpose: Self-checking bench of the hold-brake and fault monitor
// Assumes: Nominal oscillator and off-time; aux tick every 15 ref_clk cycles
// Notes:   Waits carry margin for the four-edge input synchroniser
`timescale 1ns/1ps
`define CHK(w, e, g) begin checks_done++; \
    if ((g) !== (e)) begin num_errors++; \
    $display("BAD %s exp %h got %h", w, e, g); end end
module tb_stepper_brake_and_fault_monitor;
    typedef struct { logic [1:0] sel; int inc; logic [6:0] ra; } row_t;
    logic        ref_clk, resetn, hold_in, step_sel_1, step_sel_2, step_clk, chop_off_in;
    logic        thermal_shutdown, overcurrent_shutdown, temp_hot_in, temp_cool_in;
    logic [1:0]  cur_peak_in;
    logic [3:0]  sw_q;
    logic [6:0]  ratio_a_q, ratio_b_q;
    logic        ho, hoe, fo, foe, wo, woe, home_pin, fault_pin, warn_pin, reg_wr, reg_rd, irq;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd;
    int          num_errors, checks_done, cyc;
    row_t        rows [3];

    stepper_brake_and_fault_monitor dut (
        .ref_clk(ref_clk), .resetn(resetn), .hold_in(hold_in), .step_sel_1(step_sel_1),
        .step_sel_2(step_sel_2), .step_clk(step_clk), .chop_off_in(chop_off_in),
        .thermal_shutdown(thermal_shutdown), .overcurrent_shutdown(overcurrent_shutdown),
        .temp_hot_in(temp_hot_in), .temp_cool_in(temp_cool_in), .cur_peak_in(cur_peak_in),
        .sw_q(sw_q), .ratio_a_q(ratio_a_q), .ratio_b_q(ratio_b_q),
        .angle_home_flag_o(ho), .angle_home_flag_oe(hoe), .fault_flag_o(fo), .fault_flag_oe(foe),
        .thermal_warn_flag_o(wo), .thermal_warn_flag_oe(woe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    host_flag_model host (
        .home_o(ho), .home_oe(hoe), .fault_o(fo), .fault_oe(foe), .warn_o(wo), .warn_oe(woe),
        .home_pin(home_pin), .fault_pin(fault_pin), .warn_pin(warn_pin));

    // Clock, 10 ns period
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard: the whole run needs well under 10000 cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // Register accesses: one-cycle strobes, read data sampled the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    // Step pulse wide enough to pass the synchroniser, then outputs settle
    task automatic step();
        @(posedge ref_clk) step_clk <= 1'b1;
        tick(8);
        step_clk <= 1'b0;
        tick(8);
    endtask

    task automatic set_sel(input logic [1:0] s);
        @(posedge ref_clk) {step_sel_1, step_sel_2} <= s;
        tick(12);
    endtask

    initial begin
        {hold_in, step_sel_1, step_sel_2, step_clk, chop_off_in, thermal_shutdown} = '0;
        {overcurrent_shutdown, temp_hot_in, reg_wr, reg_rd} = '0;
        temp_cool_in = 1'b1; cur_peak_in = 2'h0; reg_addr = 8'h00; reg_wdata = 32'h0;
        resetn = 1'b0;
        rows[0] = '{monitor_pkg::SEL_FULL, 4, monitor_pkg::FULL_PCT};
        rows[1] = '{monitor_pkg::SEL_HALF, 2, 7'h00};
        rows[2] = '{2'h3, 1, monitor_pkg::LOW_PCT};
        tick(2);
        @(posedge ref_clk) resetn <= 1'b1;
        tick(2);
        // Reset state of flags, mask and outputs
        `CHK("fault_rst", 1'b1, fault_pin)
        `CHK("warn_rst", 1'b1, warn_pin)
        `CHK("irq_rst", 1'b0, irq)
        rdr(monitor_pkg::MASK_OFS);
        `CHK("mask_rst", 32'h0, rd)
        rdr(8'h0c);
        `CHK("unmapped", 32'h0, rd)
        $display("test reset done");

        // Each resolution: one step moves off home, a full turn returns to it
        foreach (rows[i]) begin
            set_sel(monitor_pkg::SEL_STANDBY);
            set_sel(rows[i].sel);
            rdr(monitor_pkg::STATE_OFS);
            `CHK("angle0", monitor_pkg::INIT_ANGLE, rd[3:0])
            `CHK("home0", 1'b0, home_pin)
            step();
            rdr(monitor_pkg::STATE_OFS);
            `CHK("angle1", 4'(monitor_pkg::INIT_ANGLE + rows[i].inc), rd[3:0])
            `CHK("home1", 1'b1, home_pin)
            `CHK("ratio1", rows[i].ra, ratio_a_q)
            repeat (16 / rows[i].inc - 1) step();
            `CHK("home2", 1'b0, home_pin)
        end
        $display("test steps done");

        // Hold with chopping off closes all switches
        @(posedge ref_clk) begin hold_in <= 1'b1; chop_off_in <= 1'b1; end
        tick(8);
        `CHK("brake_sw", 4'hf, sw_q)
        // Hold with chopping: full ratio, angle still advances
        @(posedge ref_clk) chop_off_in <= 1'b0;
        set_sel(monitor_pkg::SEL_STANDBY);
        set_sel(monitor_pkg::SEL_HALF);
        step();
        `CHK("hold_ra", monitor_pkg::FULL_PCT, ratio_a_q)
        `CHK("hold_rb", monitor_pkg::FULL_PCT, ratio_b_q)
        step();
        rdr(monitor_pkg::STATE_OFS);
        `CHK("hold_ang", 4'h6, rd[3:0])
        @(posedge ref_clk) hold_in <= 1'b0;
        $display("test hold done");

        // Peak current chops both phases unless chopping is disabled
        set_sel(monitor_pkg::SEL_STANDBY);
        set_sel(monitor_pkg::SEL_FULL);
        @(posedge ref_clk) cur_peak_in <= 2'h3;
        tick(10);
        `CHK("chop_sw", 4'h0, sw_q)
        @(posedge ref_clk) chop_off_in <= 1'b1;
        tick(10);
        `CHK("nochop_sw", 4'h5, sw_q)
        @(posedge ref_clk) begin cur_peak_in <= 2'h0; chop_off_in <= 1'b0; end
        $display("test chop done");

        // Overcurrent: short burst rejected, long one latched until standby
        wr(monitor_pkg::STATUS_OFS, 32'h7);
        wr(monitor_pkg::MASK_OFS, 32'h1);
        @(posedge ref_clk) overcurrent_shutdown <= 1'b1;
        tick(75);
        @(posedge ref_clk) overcurrent_shutdown <= 1'b0;
        tick(10);
        `CHK("oc_short", 1'b1, fault_pin)
        @(posedge ref_clk) overcurrent_shutdown <= 1'b1;
        tick(200);
        @(posedge ref_clk) overcurrent_shutdown <= 1'b0;
        tick(60);
        `CHK("oc_fault", 1'b0, fault_pin)
        `CHK("oc_sw", 4'h0, sw_q)
        `CHK("oc_irq", 1'b1, irq)
        rdr(monitor_pkg::STATUS_OFS);
        `CHK("oc_status", 32'h1, rd)
        wr(monitor_pkg::STATUS_OFS, 32'h1);
        tick(1);
        `CHK("w1c_irq", 1'b0, irq)
        `CHK("oc_held", 1'b0, fault_pin)
        set_sel(monitor_pkg::SEL_STANDBY);
        set_sel(monitor_pkg::SEL_FULL);
        `CHK("standby_function_clr", 1'b1, fault_pin)
        $display("test overcurrent done");

        // Heat: 20 ticks rejected, 37 ticks latched until supply reset
        @(posedge ref_clk) thermal_shutdown <= 1'b1;
        tick(300);
        @(posedge ref_clk) thermal_shutdown <= 1'b0;
        tick(10);
        `CHK("heat_short", 1'b1, fault_pin)
        @(posedge ref_clk) thermal_shutdown <= 1'b1;
        tick(560);
        @(posedge ref_clk) thermal_shutdown <= 1'b0;
        tick(10);
        `CHK("heat_fault", 1'b0, fault_pin)
        @(posedge ref_clk) resetn <= 1'b0;
        @(posedge ref_clk) resetn <= 1'b1;
        tick(2);
        `CHK("por_clr", 1'b1, fault_pin)
        $display("test heat done");

        // Thermal warning sets when hot, holds in hysteresis, clears when cool
        @(posedge ref_clk) begin temp_hot_in <= 1'b1; temp_cool_in <= 1'b0; end
        tick(400);
        `CHK("warn_set", 1'b0, warn_pin)
        @(posedge ref_clk) temp_hot_in <= 1'b0;
        tick(300);
        `CHK("warn_hyst", 1'b0, warn_pin)
        @(posedge ref_clk) temp_cool_in <= 1'b1;
        tick(400);
        `CHK("warn_clr", 1'b1, warn_pin)
        $display("test warning done");
        test_done();
    end
endmodule
